// File: rtl/tbnc_defines.vh
// Constants of the burst transmitter oscillator and timing control.
// Assumes one 50 MHz core clock; figures below are in its cycles unless given in bits or symbol pulses.
// Contract
// - Start frequency load on first edge after strobe
// - Output frequency changes 23 cycles after load
// - Frequency forced to zero 23 after enable falls
// - Valid frequency 23 cycles after enable rises
// - Auxiliary clock high for 2 cycles
// - Auxiliary clock low for n-1 cycles, at least one
// - Symbol pulse is exactly one cycle high
// - Enable output changes one cycle after bit fall
// - Enable rises on second symbol pulse
// - Enable falls on thirteenth symbol pulse
// - Latencies hold only with block code off
// - Block code shifts both edges eight bits later
`ifndef TBNC_DEFINES_VH
`define TBNC_DEFINES_VH
`define TBNC_FW_W        32         // Frequency word width
`define TBNC_FW_ZERO     32'h00000000
`define TBNC_PIPE_W      5          // Width of the load pipeline counter
`define TBNC_LD_PIPE     5'h15      // Synced strobe to frequency change: 23 cycles less two sync stages
`define TBNC_EN_PIPE     5'h16      // Enable edge to frequency change: 23 cycles less the edge detect
`define TBNC_SEL_TAKE    5'h10      // Counter value at which the select is taken, inside both windows
`define TBNC_ACLK_HIGH   4'h2       // Auxiliary clock high cycles
`define TBNC_SYM_W       4          // Symbol counter width
`define TBNC_UP_LAT      4'h2       // Symbol pulses until enable rises
`define TBNC_DN_LAT      4'hD       // Symbol pulses until enable falls
`define TBNC_SYM_MAX     4'hF       // Symbol counter saturation
`define TBNC_BC_DELAY    8          // Block code extra delay in bits
`define TBNC_NBIT_W      12         // Bit clock half period field width
`endif

// File: rtl/tbnc_aux_clk.v
// Auxiliary clock divider: two cycles high, then n-1 cycles low, at least one.
// Assumes n is a steady configuration level on the core clock domain.
`include "tbnc_defines.vh"
`default_nettype none
module tbnc_aux_clk (
  input  wire       i_core_clk,   // Core clock
  input  wire       i_rst_b,      // Asynchronous reset, active low
  input  wire [3:0] i_aux_div_n,  // Divider value n
  output reg        o_aux_clock_out // Auxiliary clock
);
  reg  [3:0] cnt_q;   // Cycles left in the current phase
  wire [3:0] low_len; // Low phase length, at least one cycle
  assign low_len = (i_aux_div_n > 4'h1) ? (i_aux_div_n - 4'h1) : 4'h1;

  // Phase counter toggles the clock at the end of each phase
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q           <= 4'h0;
      o_aux_clock_out <= 1'b0;
    end else if (cnt_q > 4'h1) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (o_aux_clock_out) begin
      o_aux_clock_out <= 1'b0;
      cnt_q           <= low_len;
    end else begin
      o_aux_clock_out <= 1'b1;
      cnt_q           <= `TBNC_ACLK_HIGH;
    end
  end
endmodule
`default_nettype wire

// File: rtl/tbnc_burst_ctrl.v
// Burst transmitter control: oscillator word loading, bit and symbol timing,
// burst enable latency and the auxiliary clock.
// Assumes host controls arrive asynchronously and are synchronised here.
`include "tbnc_defines.vh"
`default_nettype none
module tbnc_burst_ctrl (
  input  wire                       i_core_clk,         // Core clock
  input  wire                       i_rst_b,            // Transmit reset, active low
  input  wire                       i_nco_load_strobe,  // Explicit load request
  input  wire [1:0]                 i_freq_word_select, // Selects one of four words
  input  wire [`TBNC_FW_W-1:0]      i_freq_word0,       // Frequency word 0
  input  wire [`TBNC_FW_W-1:0]      i_freq_word1,       // Frequency word 1
  input  wire [`TBNC_FW_W-1:0]      i_freq_word2,       // Frequency word 2
  input  wire [`TBNC_FW_W-1:0]      i_freq_word3,       // Frequency word 3
  input  wire                       i_burst_enable_in,  // Burst enable from host
  input  wire                       i_block_code_en,    // Block code encoder on
  input  wire [3:0]                 i_aux_div_n,        // Auxiliary clock divider n
  input  wire [`TBNC_NBIT_W-1:0]    i_bit_period_n,     // Bit clock phase is n+1 cycles
  input  wire [2:0]                 i_bits_per_symbol,  // Bits per symbol, zero taken as one
  output reg  [`TBNC_FW_W-1:0]      o_nco_freq_word,    // Word driving the oscillator
  output reg                        o_freq_valid,       // Output frequency is nonzero
  output reg                        o_bit_clock_out,    // Bit clock
  output reg                        o_symbol_pulse,     // One-cycle symbol pulse
  output reg                        o_burst_enable_out, // Burst enable to modulator
  output wire                       o_aux_clock_out     // Auxiliary clock
);
  // Two-stage synchronisers for host pins
  reg  [3:0] sync1_q;   // First stage, read only by second stage
  reg  [3:0] sync2_q;   // Second stage
  wire       ld_s;      // Synced load strobe
  wire       ben_s;     // Synced burst enable in
  wire [1:0] sel_s;     // Synced word select

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_freq_word_select, i_burst_enable_in, i_nco_load_strobe};
      sync2_q <= sync1_q;
    end
  end
  assign ld_s  = sync2_q[0];
  assign ben_s = sync2_q[1];
  assign sel_s = sync2_q[3:2];

  // Load strobe edge detect; a one-cycle strobe is still seen
  reg  ld_prev_q;   // Previous synced strobe
  wire ld_event;    // Load event pulse
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ld_prev_q <= 1'b0;
    end else begin
      ld_prev_q <= ld_s;
    end
  end
  assign ld_event = ld_s & ~ld_prev_q;

  // Bit clock: n+1 cycles high, n+1 cycles low; symbol pulse on falls
  reg  [`TBNC_NBIT_W-1:0] bit_cnt_q;   // Cycles left in bit clock phase
  reg  [2:0]              bits_q;      // Bits left in current symbol
  wire [2:0]              bits_len;    // Bits per symbol, at least one
  wire                    bit_fall;    // Bit clock goes low on this edge
  assign bits_len = (i_bits_per_symbol == 3'h0) ? 3'h1 : i_bits_per_symbol;
  assign bit_fall = (bit_cnt_q == {`TBNC_NBIT_W{1'b0}}) & o_bit_clock_out;

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_q       <= {`TBNC_NBIT_W{1'b0}};
      o_bit_clock_out <= 1'b0;
      bits_q          <= 3'h1;
      o_symbol_pulse  <= 1'b0;
    end else begin
      o_symbol_pulse <= 1'b0;
      if (bit_cnt_q != {`TBNC_NBIT_W{1'b0}}) begin
        bit_cnt_q <= bit_cnt_q - {{(`TBNC_NBIT_W-1){1'b0}}, 1'b1};
      end else begin
        bit_cnt_q       <= i_bit_period_n;
        o_bit_clock_out <= ~o_bit_clock_out;
        if (bit_fall) begin
          // Symbol boundary falls on a bit clock fall
          if (bits_q <= 3'h1) begin
            bits_q         <= bits_len;
            o_symbol_pulse <= 1'b1;
          end else begin
            bits_q <= bits_q - 3'h1;
          end
        end
      end
    end
  end

  // Bit fall marker aligned with the cycle where the bit clock is low
  reg fall_seen_q;   // High in the first low cycle of the bit clock
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fall_seen_q <= 1'b0;
    end else begin
      fall_seen_q <= bit_fall;
    end
  end

  // Symbol pulse counting after each change of the enable input
  reg  [`TBNC_SYM_W-1:0] sym_cnt_q;   // Symbol pulses since last change
  reg                    lvl_q;       // Last enable input level acted on
  reg                    en_raw_q;    // Enable before block code delay
  wire [`TBNC_SYM_W-1:0] sym_next;    // Count including this pulse
  reg                    en_raw_d;    // Next enable before delay
  assign sym_next = sym_cnt_q + {{(`TBNC_SYM_W-1){1'b0}}, 1'b1};

  // Decide enable level on the symbol pulse
  always @* begin
    en_raw_d = en_raw_q;
    if (o_symbol_pulse && (ben_s == lvl_q)) begin
      if (lvl_q && (sym_next == `TBNC_UP_LAT)) begin
        en_raw_d = 1'b1;
      end else if (!lvl_q && (sym_next == `TBNC_DN_LAT)) begin
        en_raw_d = 1'b0;
      end
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sym_cnt_q <= {`TBNC_SYM_W{1'b0}};
      lvl_q     <= 1'b0;
      en_raw_q  <= 1'b0;
    end else begin
      en_raw_q <= en_raw_d;
      if (ben_s != lvl_q) begin
        lvl_q     <= ben_s;
        sym_cnt_q <= {`TBNC_SYM_W{1'b0}};
      end else if (o_symbol_pulse && (sym_cnt_q != `TBNC_SYM_MAX)) begin
        sym_cnt_q <= sym_next;
      end
    end
  end

  // Block code delay line, advanced once per bit
  reg [`TBNC_BC_DELAY-1:0] bc_sr_q;   // Enable history in bit periods
  wire                     bc_out;    // Enable delayed by the block code
  genvar gi;
  generate
    for (gi = 0; gi < `TBNC_BC_DELAY; gi = gi + 1) begin : g_bc
      always @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          bc_sr_q[gi] <= 1'b0;
        end else if (fall_seen_q) begin
          bc_sr_q[gi] <= (gi == 0) ? en_raw_d : bc_sr_q[(gi == 0) ? 0 : gi-1];
        end
      end
    end
  endgenerate
  assign bc_out = bc_sr_q[`TBNC_BC_DELAY-1];

  // Enable output updates one cycle after the bit clock falls; the decision of a
  // symbol pulse in that same cycle is taken at once, so with block code off the edge lands on that pulse
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_burst_enable_out <= 1'b0;
    end else if (fall_seen_q) begin
      o_burst_enable_out <= i_block_code_en ? bc_out : en_raw_d;
    end
  end

  // Edges of the enable output start automatic loads and blanking
  reg  ben_out_prev_q;   // Enable output last cycle
  wire ben_rise;         // Enable output rose
  wire ben_fall;         // Enable output fell
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ben_out_prev_q <= 1'b0;
    end else begin
      ben_out_prev_q <= o_burst_enable_out;
    end
  end
  assign ben_rise = o_burst_enable_out & ~ben_out_prev_q;
  assign ben_fall = ~o_burst_enable_out & ben_out_prev_q;

  // Oscillator load pipeline: word taken inside the select window, applied after 23 cycles
  reg  [`TBNC_PIPE_W-1:0] pipe_q;    // Cycles left to frequency change, zero when idle
  reg                     zero_q;    // Pending action blanks the output
  reg  [`TBNC_FW_W-1:0]   word_q;    // Word captured for the pending load
  reg  [`TBNC_FW_W-1:0]   word_mux;  // Word picked by the select
  always @* begin
    case (sel_s)
      2'h0:    word_mux = i_freq_word0;
      2'h1:    word_mux = i_freq_word1;
      2'h2:    word_mux = i_freq_word2;
      default: word_mux = i_freq_word3;
    endcase
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pipe_q          <= {`TBNC_PIPE_W{1'b0}};
      zero_q          <= 1'b0;
      word_q          <= `TBNC_FW_ZERO;
      o_nco_freq_word <= `TBNC_FW_ZERO;
      o_freq_valid    <= 1'b0;
    end else begin
      // Start values make up for the sync and edge-detect stages, so the change
      // comes 23 edges after the edge that first saw the request
      if (ben_fall) begin
        pipe_q <= `TBNC_EN_PIPE;
        zero_q <= 1'b1;
      end else if (ben_rise) begin
        pipe_q <= `TBNC_EN_PIPE;
        zero_q <= 1'b0;
      end else if (ld_event) begin
        pipe_q <= `TBNC_LD_PIPE;
        zero_q <= 1'b0;
      end else if (pipe_q != {`TBNC_PIPE_W{1'b0}}) begin
        pipe_q <= pipe_q - {{(`TBNC_PIPE_W-1){1'b0}}, 1'b1};
        if (pipe_q == `TBNC_SEL_TAKE) begin
          word_q <= word_mux;
        end
        if (pipe_q == {{(`TBNC_PIPE_W-1){1'b0}}, 1'b1}) begin
          o_nco_freq_word <= zero_q ? `TBNC_FW_ZERO : word_q;
          o_freq_valid    <= ~zero_q;
        end
      end
    end
  end

  // Auxiliary clock divider
  tbnc_aux_clk u_aux (
    .i_core_clk      (i_core_clk),
    .i_rst_b         (i_rst_b),
    .i_aux_div_n     (i_aux_div_n),
    .o_aux_clock_out (o_aux_clock_out)
  );
endmodule
`default_nettype wire

// File: bench/tbnc_host_model.sv
// Host side model: burst enable, load strobe and word select.
// Assumes one core clock; tasks are called from the bench.
`default_nettype none
module tbnc_host_model (
  input  wire logic       i_core_clk,         // Core clock
  input  wire logic       i_burst_enable_out, // Enable seen from the block
  output var  logic       o_nco_load_strobe,  // Load request
  output var  logic [1:0] o_freq_word_select, // Word select
  output var  logic       o_burst_enable_in   // Burst request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] auto_sel = 2'h0; // Select put out one cycle after the next enable edge
  logic       en_q     = 1'b0; // Last enable level seen
  initial begin
    o_nco_load_strobe  = 1'b0;
    o_freq_word_select = 2'h0;
    o_burst_enable_in  = 1'b0;
  end
  // Put the automatic select out one cycle after an enable edge
  always @(posedge i_core_clk) begin
    en_q <= i_burst_enable_out;
    if (en_q != i_burst_enable_out) o_freq_word_select <= auto_sel;
  end
  // User load: select with the strobe, strobe one cycle, select held
  task automatic load(input logic [1:0] sel);
    @(posedge i_core_clk);
    o_freq_word_select <= sel;
    o_nco_load_strobe  <= 1'b1;
    @(posedge i_core_clk);
    o_nco_load_strobe  <= 1'b0;
    repeat (12) @(posedge i_core_clk);
  endtask
  // Change the burst request level
  task automatic burst(input logic en);
    @(posedge i_core_clk);
    o_burst_enable_in <= en;
  endtask
endmodule
`default_nettype wire

// File: bench/tbnc_burst_ctrl_sva.sv
// Checker of the burst control outputs.
// Assumes bind to the top module; static divider value.
`default_nettype none
module tbnc_burst_ctrl_sva (
  input wire logic        i_core_clk,         // Core clock
  input wire logic        i_rst_b,            // Reset, active low
  input wire logic        i_nco_load_strobe,  // Load request
  input wire logic [3:0]  i_aux_div_n,        // Divider n
  input wire logic [31:0] o_nco_freq_word,    // Oscillator word
  input wire logic        o_freq_valid,       // Frequency valid
  input wire logic        o_bit_clock_out,    // Bit clock
  input wire logic        o_symbol_pulse,     // Symbol pulse
  input wire logic        o_burst_enable_out, // Burst enable
  input wire logic        o_aux_clock_out     // Auxiliary clock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic [3:0] low_q;  // Low cycles of the auxiliary clock
  logic       seen_q; // A falling edge has been seen
  wire  [3:0] exp_lo = (i_aux_div_n < 4'h2) ? 4'h1 : i_aux_div_n - 4'h1; // Expected low span
  // Count the low span of the auxiliary clock
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_q  <= 4'h0;
      seen_q <= 1'b0;
    end else begin
      low_q <= o_aux_clock_out ? 4'h0 : low_q + 4'h1;
      if ($fell(o_aux_clock_out)) seen_q <= 1'b1;
    end
  end
  sequence s_aux_hi2;
    o_aux_clock_out [*2] ##1 !o_aux_clock_out;
  endsequence
  sequence s_word_quiet;
    $stable(o_nco_freq_word) [*8];
  endsequence
  a_sym_one_cycle: assert property (o_symbol_pulse |=> !o_symbol_pulse)
    else $error("symbol pulse longer than one cycle");
  a_aux_high_two: assert property ($rose(o_aux_clock_out) |-> s_aux_hi2)
    else $error("aux clock high span wrong");
  a_aux_low_len: assert property ($rose(o_aux_clock_out) && seen_q |-> low_q == exp_lo)
    else $error("aux clock low span wrong");
  a_en_bit_align: assert property ($changed(o_burst_enable_out) |-> !$past(o_bit_clock_out))
    else $error("enable edge not after bit clock low");
  a_zero_after_fall: assert property ($fell(o_burst_enable_out) |-> ##[22:24] !o_freq_valid)
    else $error("frequency not zero after enable fall");
  a_hold_before_zero: assert property ($fell(o_burst_enable_out) && o_freq_valid |=> o_freq_valid [*8])
    else $error("frequency dropped early");
  a_valid_after_rise: assert property ($rose(o_burst_enable_out) |-> ##[22:24] o_freq_valid)
    else $error("frequency not valid after enable rise");
  a_load_not_early: assert property ($rose(i_nco_load_strobe) && o_freq_valid |=> s_word_quiet)
    else $error("word changed before load latency");
endmodule
`default_nettype wire

// File: bench/tb.sv
// Bench of the burst control: loads, enable latencies, reset.
// Assumes design, host model and checker compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] sel; logic [31:0] exp;} tbnc_row_t;
  logic        i_core_clk = 1'b0; // Core clock
  logic        i_rst_b    = 1'b0; // Reset, active low
  logic        blk_en     = 1'b0; // Block code on
  logic [31:0] fw [4] = '{32'h01234567, 32'h089ABCDE, 32'h0F0F0F0F, 32'h0EDCBA98}; // Words
  tbnc_row_t   rows [4] = '{'{2'h1, 32'h089ABCDE}, '{2'h3, 32'h0EDCBA98},
                            '{2'h0, 32'h01234567}, '{2'h2, 32'h0F0F0F0F}}; // Select, word
  wire         strobe, en_in, en_out, sym, valid; // Control lines
  wire  [1:0]  sel;   // Word select
  wire  [31:0] word;  // Oscillator word
  int          n_fail = 0;
  int          total_checks = 0;
  always #10 i_core_clk = ~i_core_clk;
  tbnc_host_model tbnc_host_model_i (.i_core_clk(i_core_clk), .i_burst_enable_out(en_out),
    .o_nco_load_strobe(strobe), .o_freq_word_select(sel), .o_burst_enable_in(en_in));
  tbnc_burst_ctrl tbnc_burst_ctrl_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_nco_load_strobe(strobe), .i_freq_word_select(sel), .i_freq_word0(fw[0]),
    .i_freq_word1(fw[1]), .i_freq_word2(fw[2]), .i_freq_word3(fw[3]), .i_burst_enable_in(en_in),
    .i_block_code_en(blk_en), .i_aux_div_n(4'h4), .i_bit_period_n(12'h001), .i_bits_per_symbol(3'h2),
    .o_nco_freq_word(word), .o_freq_valid(valid), .o_bit_clock_out(), .o_symbol_pulse(sym),
    .o_burst_enable_out(en_out), .o_aux_clock_out());
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Change the burst request just after a symbol pulse
  task automatic kick(input logic lvl);
    wait (sym === 1'b1);
    tbnc_host_model_i.burst(lvl);
  endtask
  // Count symbol pulses until the enable output reaches a level
  task automatic pulses_to(input logic lvl, output int n);
    n = 0;
    for (int t = 0; t < 3000 && en_out !== lvl; t++) begin
      @(negedge i_core_clk);
      if (sym === 1'b1) n++;
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    test_done;
  end
  // Main sequence
  initial begin
    int n;
    repeat (2) @(posedge i_core_clk);
    chk("reset_out", 32'h0, word | {30'h0, en_out, valid});
    i_rst_b <= 1'b1;
    repeat (50) @(posedge i_core_clk);
    chk("idle_out", 32'h0, word | {30'h0, en_out, valid});
    tbnc_host_model_i.auto_sel = 2'h2;
    kick(1'b1);
    pulses_to(1'b1, n);
    chk("pulses_up", 32'd2, n);
    repeat (30) @(posedge i_core_clk);
    chk("auto_word", fw[2], word);
    foreach (rows[i]) begin
      tbnc_host_model_i.load(rows[i].sel);
      repeat (20) @(posedge i_core_clk);
      chk("load_word", rows[i].exp, word);
    end
    // Drop the request briefly, then raise it again before the fall
    kick(1'b0);
    repeat (5) @(posedge sym);
    kick(1'b1);
    repeat (20) @(posedge sym);
    chk("restart_en", 32'h1, {31'h0, en_out});
    kick(1'b0);
    pulses_to(1'b0, n);
    chk("pulses_down", 32'd13, n);
    repeat (30) @(posedge i_core_clk);
    chk("zero_out", 32'h0, word | {31'h0, valid});
    // Block code on: both edges four symbols later
    blk_en <= 1'b1;
    kick(1'b1);
    pulses_to(1'b1, n);
    chk("pulses_up_bc", 32'd6, n);
    kick(1'b0);
    pulses_to(1'b0, n);
    chk("pulses_down_bc", 32'd17, n);
    // Reset in mid-burst: enable low, frequency zero, and no burst after release
    kick(1'b1);
    pulses_to(1'b1, n);
    repeat (30) @(posedge i_core_clk);
    chk("bc_word", fw[2], word);
    i_rst_b <= 1'b0;
    tbnc_host_model_i.burst(1'b0);
    chk("midrst_out", 32'h0, word | {30'h0, en_out, valid});
    i_rst_b <= 1'b1;
    repeat (60) @(posedge i_core_clk);
    chk("postrst_out", 32'h0, word | {30'h0, en_out, valid});
    test_done;
  end
endmodule
bind tbnc_burst_ctrl tbnc_burst_ctrl_sva tbnc_burst_ctrl_sva_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_nco_load_strobe(i_nco_load_strobe), .i_aux_div_n(i_aux_div_n), .o_nco_freq_word(o_nco_freq_word),
  .o_freq_valid(o_freq_valid), .o_bit_clock_out(o_bit_clock_out), .o_symbol_pulse(o_symbol_pulse),
  .o_burst_enable_out(o_burst_enable_out), .o_aux_clock_out(o_aux_clock_out));
`default_nettype wire
